// file: dwss_pkg.sv
// Constants, register map and types for the dual wiper serial slave.
// Assumes a 50 MHz hclk; the files that use these names refer to them through dwss_pkg::.
package dwss_pkg;
    localparam int          CLK_FREQ_HZ      = 50_000_000;
    localparam int          CLK_PER_US       = CLK_FREQ_HZ / 1_000_000;
    // Longest times, rounded down to whole cycles
    localparam int          NV_WRITE_TIME_US = 20_000;
    localparam int          NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLK_PER_US;
    localparam int          POWER_UP_TIME_US = 3_000;
    localparam int          POWER_UP_CYCLES  = POWER_UP_TIME_US * CLK_PER_US;
    // Device type code; value is arbitrary
    localparam logic [3:0]  ID_TYPE_CODE     = 4'h6;
    localparam logic [6:0]  WIPER_RESET      = 7'h40;
    // Contents of the non-volatile cells at first power; arbitrary
    localparam logic [7:0]  NV_RESET         = 8'h40;
    localparam int          NV_DEPTH         = 7;
    // Serial register addresses
    localparam logic [7:0]  LREG_WIPER1      = 8'h01;
    localparam logic [7:0]  LREG_GP_LAST     = 8'h06;
    localparam logic [7:0]  LREG_ACR         = 8'h08;
    localparam int          ACR_VOL_BIT      = 7;
    localparam int          ACR_SHUTDOWN_REQUEST_BIT     = 6;
    localparam int          ACR_WIP_BIT      = 5;
    localparam logic        ACR_VOL_RESET    = 1'b0;
    localparam logic        ACR_SHUTDOWN_REQUEST_RESET   = 1'b1;
    // Bus register byte offsets
    localparam logic [7:0]  AHB_WIPER0       = 8'h00;
    localparam logic [7:0]  AHB_WIPER1       = 8'h04;
    localparam logic [7:0]  AHB_ACR          = 8'h08;
    localparam logic [7:0]  AHB_INIT0        = 8'h0c;
    localparam logic [7:0]  AHB_INIT1        = 8'h10;
    localparam logic [7:0]  AHB_STATUS       = 8'h14;
    localparam logic [7:0]  AHB_IRQ_STATUS   = 8'h18;
    localparam logic [7:0]  AHB_IRQ_MASK     = 8'h1c;
    // Interrupt bits
    localparam int          IRQ_WIDTH        = 3;
    localparam int          IRQ_NV_DONE      = 0;
    localparam int          IRQ_LINK_WRITE   = 1;
    localparam int          IRQ_SHUTDOWN     = 2;
    localparam logic [2:0]  IRQ_RESET        = 3'h0;
    localparam logic [3:0]  BIT_LAST         = 4'h8;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'b000,
        LINK_RX   = 3'b001,
        LINK_ACK  = 3'b011,
        LINK_TX   = 3'b010,
        LINK_MACK = 3'b110
    } dwss_link_state_type;
endpackage

// file: dwss_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes inputs may change at any time relative to hclk.
`timescale 1ns/1ps
module dwss_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// file: dwss_timer.sv
// One-shot cycle timer: busy for CYCLES clocks after a start pulse.
// Assumes start is a one-cycle pulse in the hclk domain.
`timescale 1ns/1ps
module dwss_timer #(
    parameter int CYCLES = 4
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            done <= busy && (count == CW'(1));
            if (start && !busy)
            begin
                count <= CW'(CYCLES);
                busy  <= 1'b1;
            end
            else if (busy)
            begin
                count <= count - CW'(1);
                busy  <= (count != CW'(1));
            end
        end
    end
endmodule

// file: dwss_top.sv
// Dual wiper control with two-wire serial slave and AHB-Lite registers.
// Assumes scl, sda and pins are asynchronous; external pull-up on sda.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dwss_top #(
    parameter int NV_WRITE_CYCLES = dwss_pkg::NV_WRITE_CYCLES,
    parameter int POWER_UP_CYCLES = dwss_pkg::POWER_UP_CYCLES
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             irq,
    // Serial link
    input  wire logic        scl,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    // Pins
    input  wire logic        addr_select_2,
    input  wire logic        addr_select_1,
    input  wire logic        addr_select_0,
    input  wire logic        shutdown_request,
    // Wiper control
    output logic [6:0]       wiper_tap_0,
    output logic [6:0]       wiper_tap_1,
    output logic [1:0]       high_terminal_en,
    output logic [1:0]       wiper_to_low,
    output logic             nv_write_pending
);
    logic [5:0]                    pins_s;
    logic                          scl_s, sda_s, shutdown_request_pin_s;
    logic [2:0]                    addr_s;
    logic                          scl_q, sda_q;
    dwss_pkg::dwss_link_state_type state;
    logic [3:0]                    bit_cnt;
    logic [7:0]                    shift;
    logic [1:0]                    byte_idx;
    logic                          rw;
    logic [7:0]                    reg_ptr;
    logic [6:0]                    wiper_pos [2];
    logic [7:0]                    initial_wiper_store [dwss_pkg::NV_DEPTH];
    logic                          acr_vol, acr_shutdown_request;
    logic                          nv_dirty, nv_busy, nv_done;
    logic                          por_kick, por_done, link_ready;
    logic                          dp_write;
    logic [7:0]                    dp_addr;
    logic [2:0]                    irq_status, irq_mask;
    logic                          shut_q;

    dwss_sync #(.WIDTH(6)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({scl, sda_i, shutdown_request,
                    addr_select_2, addr_select_1, addr_select_0}),
        .sync_out (pins_s)
    );
    assign scl_s      = pins_s[5];
    assign sda_s      = pins_s[4];
    assign shutdown_request_pin_s = pins_s[3];
    assign addr_s     = pins_s[2:0];

    // Line events on synchronised samples
    wire scl_rise  = scl_s && !scl_q;
    wire scl_fall  = !scl_s && scl_q;
    wire start_det = scl_s && scl_q && sda_q && !sda_s;
    wire stop_det  = scl_s && scl_q && !sda_q && sda_s;
    wire byte_end  = (state == dwss_pkg::LINK_RX) && scl_fall
                     && (bit_cnt == dwss_pkg::BIT_LAST);
    wire id_match  = (shift[7:4] == dwss_pkg::ID_TYPE_CODE)
                     && (shift[3:1] == addr_s);
    wire shut      = !(shutdown_request_pin_s && acr_shutdown_request);
    wire in_gp     = reg_ptr <= dwss_pkg::LREG_GP_LAST;
    wire in_wiper  = reg_ptr <= dwss_pkg::LREG_WIPER1;

    function automatic logic [7:0] link_read(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == dwss_pkg::LREG_ACR)
            v = {acr_vol, acr_shutdown_request, nv_busy, 5'h00};
        else if (a <= dwss_pkg::LREG_WIPER1 && acr_vol)
            v = {1'b0, wiper_pos[a[0]]};
        else if (a <= dwss_pkg::LREG_GP_LAST && !acr_vol)
            v = initial_wiper_store[a[2:0]];
        return v;
    endfunction
    wire [7:0] rd_byte = link_read(reg_ptr);

    // Link register writes, blocked during a non-volatile cycle
    wire link_wr  = byte_end && (byte_idx == 2'd2) && !rw;
    wire link_ok  = link_wr && !nv_busy;
    wire lw_vol   = link_ok && in_wiper && acr_vol;
    wire lw_nv    = link_ok && in_gp && !acr_vol;
    wire lw_acr   = link_ok && (reg_ptr == dwss_pkg::LREG_ACR);

    // Serial link state machine
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            state    <= dwss_pkg::LINK_IDLE;
            bit_cnt  <= 4'h0;
            shift    <= 8'h00;
            byte_idx <= 2'd0;
            rw       <= 1'b0;
            reg_ptr  <= 8'h00;
            sda_oe_n <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            if (start_det && link_ready)
            begin
                state    <= dwss_pkg::LINK_RX;
                bit_cnt  <= 4'h0;
                byte_idx <= 2'd0;
                sda_oe_n <= 1'b1;
            end
            else if (stop_det)
            begin
                state    <= dwss_pkg::LINK_IDLE;
                sda_oe_n <= 1'b1;
            end
            else
            begin
                unique case (state)
                    dwss_pkg::LINK_IDLE:
                        sda_oe_n <= 1'b1;
                    dwss_pkg::LINK_RX:
                        if (scl_rise)
                        begin
                            shift   <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (byte_end)
                        begin
                            if (byte_idx == 2'd0 && !id_match)
                                state <= dwss_pkg::LINK_IDLE;
                            else
                            begin
                                state    <= dwss_pkg::LINK_ACK;
                                sda_oe_n <= 1'b0;
                            end
                            if (byte_idx == 2'd0)
                                rw <= shift[0];
                            if (byte_idx == 2'd1)
                                reg_ptr <= shift;
                            if (byte_idx != 2'd2)
                                byte_idx <= byte_idx + 2'd1;
                        end
                    dwss_pkg::LINK_ACK:
                        if (scl_fall)
                        begin
                            if (rw)
                            begin
                                state    <= dwss_pkg::LINK_TX;
                                shift    <= {rd_byte[6:0], 1'b0};
                                sda_oe_n <= rd_byte[7];
                                bit_cnt  <= 4'h1;
                            end
                            else
                            begin
                                state    <= dwss_pkg::LINK_RX;
                                sda_oe_n <= 1'b1;
                                bit_cnt  <= 4'h0;
                            end
                        end
                    dwss_pkg::LINK_TX:
                        if (scl_fall)
                        begin
                            if (bit_cnt == dwss_pkg::BIT_LAST)
                            begin
                                state    <= dwss_pkg::LINK_MACK;
                                sda_oe_n <= 1'b1;
                            end
                            else
                            begin
                                sda_oe_n <= shift[7];
                                shift    <= {shift[6:0], 1'b0};
                                bit_cnt  <= bit_cnt + 4'h1;
                            end
                        end
                    dwss_pkg::LINK_MACK:
                        if (scl_rise && sda_s)
                            state <= dwss_pkg::LINK_IDLE;
                        else if (scl_fall)
                        begin
                            state    <= dwss_pkg::LINK_TX;
                            shift    <= {rd_byte[6:0], 1'b0};
                            sda_oe_n <= rd_byte[7];
                            bit_cnt  <= 4'h1;
                        end
                    default:
                        state <= dwss_pkg::LINK_IDLE;
                endcase
            end
        end
    end

    // Power-up: wipers at reset value, then recall
    dwss_timer #(.CYCLES(POWER_UP_CYCLES)) u_por (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (!por_kick),
        .busy    (),
        .done    (por_done)
    );
    dwss_timer #(.CYCLES(NV_WRITE_CYCLES)) u_nvw (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (stop_det && nv_dirty),
        .busy    (nv_busy),
        .done    (nv_done)
    );

    // AHB-Lite decode, zero wait states
    wire ahb_take = hsel && hready && htrans[1];
    wire aw_ok    = dp_write && !nv_busy;
    wire aw_acr   = aw_ok && (dp_addr == dwss_pkg::AHB_ACR);
    wire aw_irqs  = dp_write && (dp_addr == dwss_pkg::AHB_IRQ_STATUS);
    wire aw_mask  = dp_write && (dp_addr == dwss_pkg::AHB_IRQ_MASK);
    wire [1:0] aw_wiper = {aw_ok && (dp_addr == dwss_pkg::AHB_WIPER1),
                           aw_ok && (dp_addr == dwss_pkg::AHB_WIPER0)};
    wire [7:0] ra = haddr[7:0];
    wire [31:0] ahb_rd =
        (ra == dwss_pkg::AHB_WIPER0)     ? {25'h0, wiper_pos[0]} :
        (ra == dwss_pkg::AHB_WIPER1)     ? {25'h0, wiper_pos[1]} :
        (ra == dwss_pkg::AHB_ACR)        ?
            {24'h0, acr_vol, acr_shutdown_request, nv_busy, 5'h00} :
        (ra == dwss_pkg::AHB_INIT0)      ? {24'h0, initial_wiper_store[0]} :
        (ra == dwss_pkg::AHB_INIT1)      ? {24'h0, initial_wiper_store[1]} :
        (ra == dwss_pkg::AHB_STATUS)     ?
            {27'h0, nv_busy, addr_s, shut} :
        (ra == dwss_pkg::AHB_IRQ_STATUS) ? {29'h0, irq_status} :
        (ra == dwss_pkg::AHB_IRQ_MASK)   ? {29'h0, irq_mask} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write  <= 1'b0;
            dp_addr   <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            dp_write  <= ahb_take && hwrite;
            dp_addr   <= ra;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ahb_take && !hwrite)
                hrdata <= ahb_rd;
        end
    end

    // Wiper registers, one per channel
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_wiper
            wire lw_hit = (lw_vol || lw_nv) && (reg_ptr[0] == ch[0])
                          && in_wiper;
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    wiper_pos[ch] <= dwss_pkg::WIPER_RESET;
                else if (por_done)
                    wiper_pos[ch] <= initial_wiper_store[ch][6:0];
                else if (lw_hit)
                    wiper_pos[ch] <= shift[6:0];
                else if (aw_wiper[ch])
                    wiper_pos[ch] <= hwdata[6:0];
            end
        end
    endgenerate

    // Non-volatile cells and access control
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < dwss_pkg::NV_DEPTH; i++)
                initial_wiper_store[i] <= dwss_pkg::NV_RESET;
            acr_vol    <= dwss_pkg::ACR_VOL_RESET;
            acr_shutdown_request   <= dwss_pkg::ACR_SHUTDOWN_REQUEST_RESET;
            nv_dirty   <= 1'b0;
            por_kick   <= 1'b0;
            link_ready <= 1'b0;
        end
        else
        begin
            por_kick <= 1'b1;
            if (por_done)
                link_ready <= 1'b1;
            if (lw_nv)
                initial_wiper_store[reg_ptr[2:0]] <= shift;
            if (lw_nv)
                nv_dirty <= 1'b1;
            else if (stop_det)
                nv_dirty <= 1'b0;
            if (lw_acr)
            begin
                acr_vol  <= shift[dwss_pkg::ACR_VOL_BIT];
                acr_shutdown_request <= shift[dwss_pkg::ACR_SHUTDOWN_REQUEST_BIT];
            end
            else if (aw_acr)
            begin
                acr_vol  <= hwdata[dwss_pkg::ACR_VOL_BIT];
                acr_shutdown_request <= hwdata[dwss_pkg::ACR_SHUTDOWN_REQUEST_BIT];
            end
        end
    end

    // Interrupts: set wins over write-one-to-clear
    wire [2:0] irq_event = {shut && !shut_q, link_ok, nv_done};
    wire [2:0] irq_clr   = aw_irqs ? hwdata[2:0] : 3'h0;

    // Registered outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status       <= dwss_pkg::IRQ_RESET;
            irq_mask         <= dwss_pkg::IRQ_RESET;
            irq              <= 1'b0;
            shut_q           <= 1'b0;
            wiper_tap_0      <= dwss_pkg::WIPER_RESET;
            wiper_tap_1      <= dwss_pkg::WIPER_RESET;
            high_terminal_en <= 2'h0;
            wiper_to_low     <= 2'h3;
            nv_write_pending <= 1'b0;
            sda_o            <= 1'b0;
        end
        else
        begin
            irq_status <= irq_event | (irq_status & ~irq_clr);
            if (aw_mask)
                irq_mask <= hwdata[2:0];
            irq              <= |(irq_status & irq_mask);
            shut_q           <= shut;
            wiper_tap_0      <= wiper_pos[0];
            wiper_tap_1      <= wiper_pos[1];
            high_terminal_en <= {2{!shut}};
            wiper_to_low     <= {2{shut}};
            nv_write_pending <= nv_busy;
            sda_o            <= 1'b0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_tap_follows_code: assert property (
        ##1 wiper_tap_1 == $past(wiper_pos[1]))
        else $error("tap 1 does not follow its code");
    a_tap_own_channel: assert property (
        aw_wiper == 2'b01 && !por_done && !lw_vol && !lw_nv
        |=> ##1 wiper_tap_0 == $past(hwdata[6:0], 2)
        && $stable(wiper_tap_1))
        else $error("channel write leaked or lost");
    a_shut_terminals: assert property (
        shut |=> high_terminal_en == 2'h0 && wiper_to_low == 2'h3)
        else $error("shutdown terminals wrong");
    a_shut_keeps_code: assert property (
        shut != shut_q && !lw_vol && !lw_nv && aw_wiper == 2'h0 && !por_done
        |=> $stable(wiper_pos[0]) && $stable(wiper_pos[1]))
        else $error("code changed on shutdown edge");
    a_shut_and: assert property (
        !acr_shutdown_request || !shutdown_request_pin_s |=> high_terminal_en == 2'h0)
        else $error("shutdown not forced");
    a_link_in_shut: assert property (
        lw_vol && shut && reg_ptr == 8'h00 && !por_done
        |=> wiper_pos[0] == $past(shift[6:0]))
        else $error("write lost in shutdown");
    a_rx_sample_rise: assert property (
        state == dwss_pkg::LINK_RX && scl_rise && !start_det && !stop_det
        |=> shift[0] == $past(sda_s))
        else $error("bit not sampled on rise");
    a_sda_after_fall: assert property (
        sda_oe_n != $past(sda_oe_n) && !$past(start_det) && !$past(stop_det)
        && $past(state) != dwss_pkg::LINK_IDLE |-> $past(scl_fall))
        else $error("data changed away from clock fall");
    a_drive_low_only: assert property (
        sda_o == 1'b0)
        else $error("data line driven high");
    a_addr_mismatch: assert property (
        byte_end && byte_idx == 2'd0 && !id_match && !start_det && !stop_det
        |=> state == dwss_pkg::LINK_IDLE && sda_oe_n)
        else $error("foreign address answered");
    a_nv_self_timed: assert property (
        stop_det && nv_dirty && !nv_busy |=> ##1 nv_busy [*3])
        else $error("non-volatile cycle not started");
    a_recall_load: assert property (
        por_done |=> wiper_pos[0] == $past(initial_wiper_store[0][6:0]))
        else $error("recall did not load");
    a_wip_blocks: assert property (
        nv_busy && (link_wr || dp_write) && !por_done
        |=> $stable(wiper_pos[0]) && $stable(wiper_pos[1]))
        else $error("write accepted during non-volatile cycle");

    c_link_read:  cover property (state == dwss_pkg::LINK_MACK && scl_fall);
    c_nv_done:    cover property (nv_done);
    c_shut_enter: cover property (shut && !shut_q);
    c_irq:        cover property ($rose(irq));
endmodule

// file: dwss_master.sv
// Serial bus master model: clock and open-drain data.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module dwss_master (
    // Link
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial scl = 1'b1;
    initial sda_low = 1'b0;
    // Data bits change only while the clock is low; start and stop change data with the clock high
    task automatic put_bit(input logic b);
        #40 sda_low = ~b;
        #40 scl = 1'b1;
        #80 scl = 1'b0;
    endtask
    task automatic frame_start;
        #80 sda_low = 1'b1;
        #80 scl = 1'b0;
    endtask
    task automatic frame_stop;
        #40 sda_low = 1'b1;
        #40 scl = 1'b1;
        #80 sda_low = 1'b0;
        #80;
    endtask
    // MSB first, then the receiver's acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(b[i]);
        #40 sda_low = 1'b0;
        #40 scl = 1'b1;
        #40 ack = ~sda;
        #40 scl = 1'b0;
    endtask
    // Eight bits in, MSB first, then a not-acknowledge
    task automatic recv_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            #80 scl = 1'b1;
            #40 b[i] = sda;
            #40 scl = 1'b0;
        end
        put_bit(1'b1);
    endtask
endmodule

// file: testbench.sv
// Self-checking bench for dwss_top with a serial master model.
// Assumes shortened timing parameters and a pull-up on data.
`timescale 1ns/1ps
module testbench;
    typedef struct {
        logic [7:0]  addr;
        logic [31:0] data;
        logic        pin;
        logic [13:0] taps;
        logic [1:0]  hte;
    } dwss_row_type;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  pins = 3'h5, acks;
    logic        sdn_pin = 1'b1;
    int          bad_count = 0, total_checks = 0;
    wire         hreadyout, irq, scl, sda_low, sda_oe_n, nv_busy;
    wire         hresp, sda_o;
    logic [7:0]  rdb;
    wire  [31:0] hrdata;
    wire  [6:0]  tap0, tap1;
    wire  [1:0]  hte, wtl;
    wire         sda = ~sda_low & (sda_oe_n | sda_o);
    dwss_row_type rows [5] = '{
        '{8'h00, 32'h7f, 1'b1, 14'h3fc0, 2'h3},
        '{8'h04, 32'h00, 1'b1, 14'h3f80, 2'h3},
        '{8'h08, 32'h80, 1'b1, 14'h3f80, 2'h0},
        '{8'h08, 32'hc0, 1'b0, 14'h3f80, 2'h0},
        '{8'h08, 32'hc0, 1'b1, 14'h3f80, 2'h3}};
    dwss_top #(.NV_WRITE_CYCLES(50), .POWER_UP_CYCLES(20)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .irq(irq), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .addr_select_2(pins[2]),
        .addr_select_1(pins[1]), .addr_select_0(pins[0]),
        .shutdown_request(sdn_pin), .wiper_tap_0(tap0),
        .wiper_tap_1(tap1), .high_terminal_en(hte), .wiper_to_low(wtl),
        .nv_write_pending(nv_busy));
    dwss_master i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
    always #10 hclk = ~hclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge hclk);
        end
        if (n >= 50)
        begin
            bad_count++;
            close_out;
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic link_wr(input logic [7:0] id, ra, d);
        i_mst.frame_start;
        i_mst.send_byte(id, acks[2]);
        i_mst.send_byte(ra, acks[1]);
        i_mst.send_byte(d, acks[0]);
        i_mst.frame_stop;
        @(posedge hclk);
    endtask
    task automatic link_rd(output logic [7:0] d);
        i_mst.frame_start;
        i_mst.send_byte({dwss_pkg::ID_TYPE_CODE, pins, 1'b1}, acks[2]);
        i_mst.recv_byte(d);
        i_mst.frame_stop;
        @(posedge hclk);
    endtask
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, dwss_pkg::AHB_ACR, 32'h0);
        chk(rd, 32'h40);
        repeat (30) @(posedge hclk);
        foreach (rows[i])
        begin
            sdn_pin <= rows[i].pin;
            ahb(1'b1, rows[i].addr, rows[i].data);
            repeat (6) @(posedge hclk);
            chk({18'h0, tap0, tap1}, {18'h0, rows[i].taps});
            chk({30'h0, hte}, {30'h0, rows[i].hte});
            chk({30'h0, wtl}, {30'h0, ~rows[i].hte});
            ahb(1'b0, rows[i].addr, 32'h0);
            chk(rd, rows[i].data);
            chk({31'h0, hresp}, 32'h0);
        end
        ahb(1'b1, dwss_pkg::AHB_IRQ_MASK, 32'h2);
        sdn_pin <= 1'b0;
        link_wr({dwss_pkg::ID_TYPE_CODE, pins, 1'b0}, 8'h00, 8'h15);
        repeat (4) @(posedge hclk);
        chk({29'h0, acks}, 32'h7);
        chk({25'h0, tap0}, 32'h15);
        chk({31'h0, irq}, 32'h1);
        chk({30'h0, hte}, 32'h0);
        sdn_pin <= 1'b1;
        ahb(1'b1, dwss_pkg::AHB_IRQ_STATUS, 32'h2);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        link_wr({dwss_pkg::ID_TYPE_CODE, 3'h4, 1'b0}, 8'h00, 8'h55);
        chk({31'h0, acks[2]}, 32'h0);
        chk({25'h0, tap0}, 32'h15);
        ahb(1'b1, dwss_pkg::AHB_ACR, 32'h40);
        link_wr({dwss_pkg::ID_TYPE_CODE, pins, 1'b0}, 8'h01, 8'h22);
        repeat (4) @(posedge hclk);
        chk({31'h0, nv_busy}, 32'h1);
        ahb(1'b1, dwss_pkg::AHB_WIPER1, 32'h33);
        repeat (60) @(posedge hclk);
        chk({31'h0, nv_busy}, 32'h0);
        chk({25'h0, tap1}, 32'h22);
        ahb(1'b0, dwss_pkg::AHB_IRQ_STATUS, 32'h0);
        chk(rd, 32'h7);
        ahb(1'b0, dwss_pkg::AHB_STATUS, 32'h0);
        chk(rd, 32'h0a);
        link_rd(rdb);
        chk({31'h0, acks[2]}, 32'h1);
        chk({24'h0, rdb}, 32'h22);
        // Reset in mid-run
        hresetn <= 1'b0;
        @(posedge hclk);
        chk({18'h0, tap0, tap1}, 32'h2040);
        chk({28'h0, hte, wtl}, 32'h3);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({18'h0, tap0, tap1}, 32'h2040);
        close_out;
    end
endmodule
